// ### common/haptic_drive_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef HAPTIC_DRIVE_MAP_SVH
`define HAPTIC_DRIVE_MAP_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define CTL2_ADDR 8'h1C
`define CTL3_ADDR 8'h1D
`define CTL2_RST 8'hDA
`define CTL3_RST 8'hA0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTL2_TWO_SIDED_BIT 7
`define CTL2_GAIN_REDUCE_BIT 6
`define CTL2_SAMPLE_HI 5
`define CTL2_SAMPLE_LO 4
`define CTL2_BLANK_HI 3
`define CTL2_BLANK_LO 2
`define CTL2_DECAY_HI 1
`define CTL2_DECAY_LO 0
`define CTL3_GATE_HI 7
`define CTL3_GATE_LO 6
`define CTL3_ROT_LOOP_BIT 5
`define CTL3_SUPPLY_OFF_BIT 4
`define CTL3_SIGNEDNESS_BIT 3
`define CTL3_RATE_BIT 2
`define CTL3_ANALOG_BIT 1
`define CTL3_FIXED_FREQ_BIT 0

// ----------------------------------------------------------------
// Mode codes, levels and thresholds
// ----------------------------------------------------------------
`define MODE_PIN_INPUT 3'h3
`define LEVEL_MID 8'h80
`define GATE_THR_1 8'h05
`define GATE_THR_2 8'h0A
`define GATE_THR_3 8'h14
`define COMMUT_EDGE_LAST 6'h3F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 250
`define SAMPLE_TIME0_US 150
`define SAMPLE_TIME1_US 200
`define SAMPLE_TIME2_US 250
`define SAMPLE_TIME3_US 300
`define BLANK_STEP_NS 100
`define DECAY_STEP_NS 100
`define BLANK_STEP_CYC ((`BLANK_STEP_NS * `CLK_MHZ) / 1000)
`define DECAY_STEP_CYC ((`DECAY_STEP_NS * `CLK_MHZ) / 1000)
`define DUTY_WIN_BITS_DEF 16

`endif

// ### common/haptic_drive_pkg.sv
// Types shared by the haptic drive configuration logic
package haptic_drive_pkg;

    typedef enum logic [1:0] {
        src_playback = 2'b00,
        src_pwm = 2'b01,
        src_analog = 2'b10
    } input_source_e;

    typedef struct packed {
        logic [16:0] count;
        logic busy;
        logic done;
    } timer_state_s;

    typedef struct packed {
        logic [7:0] ctl2;
        logic [7:0] ctl3;
        logic [7:0] act2;
        logic [7:0] act3;
        logic [7:0] rdata;
        logic [15:0] win_cnt;
        logic [16:0] high_cnt;
        logic [7:0] duty;
        logic pin_prev;
        logic [5:0] edge_cnt;
        logic commut;
        logic phase;
        logic [7:0] drive;
        logic brake;
        logic gain_red;
        logic supply_on;
        logic adc_sample;
        logic update;
        logic decay;
    } drive_state_s;

endpackage

// ### verilog/interval_timer.sv
// One-shot interval timer with busy level and done pulse
`timescale 1ns/1ns
`default_nettype none

module interval_timer
    import haptic_drive_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Control
    input wire logic start_in,
    input wire logic [16:0] length_in,
    // Status
    output logic busy_out,
    output logic done_out
);

    timer_state_s st_reg;
    timer_state_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (start_in) begin
            st_next.count = (length_in == 17'h00000) ? 17'h00001 : length_in;
            st_next.busy = 1'b1;
        end else if (st_reg.busy) begin
            if (st_reg.count == 17'h00001) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.count = st_reg.count - 17'h00001;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_out = st_reg.busy;
    assign done_out = st_reg.done;

endmodule

`default_nettype wire

// ### verilog/haptic_drive_config_regs.sv
// Drive engine configuration registers and input-to-drive mapping
`timescale 1ns/1ns
`default_nettype none
`include "haptic_drive_map.svh"

// Contract
// R01: control two bit 7 selects two-sided input
// R02: open-loop two-sided brakes only below half scale
// R03: open-loop two-sided maps level linearly to drive
// R04: closed-loop two-sided drives only above half scale
// R05: brake gain reduce lowers gain near brake end
// R06: sample field picks 150/200/250/300 us interval
// R07: blanking field sets wait before converter sample
// R08: decay field sets current decay between cycles
// R09: noise gate threshold off, 2, 4, 8 percent
// R10: bit 5 picks rotating-mass open or closed loop
// R11: bit 4 turns supply correction off
// R12: bit 3 sets playback word signedness
// R13: bit 2 sets once or twice per cycle
// R14: mode 3 bit 1 picks PWM or analog
// R15: amplitude from duty cycle or analog level
// R16: bit 0 picks fixed frequency linear drive
// R17: fixed-frequency commutation is PWM frequency over 128
// R18: unused codes ignored; writes apply next update
module haptic_drive_config_regs
    import haptic_drive_pkg::*;
#(
    parameter logic [16:0] SAMPLE_CYC0 = 17'(`SAMPLE_TIME0_US * `CLK_MHZ),
    parameter logic [16:0] SAMPLE_CYC1 = 17'(`SAMPLE_TIME1_US * `CLK_MHZ),
    parameter logic [16:0] SAMPLE_CYC2 = 17'(`SAMPLE_TIME2_US * `CLK_MHZ),
    parameter logic [16:0] SAMPLE_CYC3 = 17'(`SAMPLE_TIME3_US * `CLK_MHZ),
    parameter int DUTY_WIN_BITS = `DUTY_WIN_BITS_DEF
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Engine inputs
    input wire logic [2:0] mode_in,
    input wire logic lra_select_in,
    input wire logic [7:0] real_time_playback_in,
    input wire logic [7:0] analog_level_in,
    input wire logic trigger_input_pin_in,
    input wire logic feedback_brake_in,
    input wire logic brake_near_done_in,
    input wire logic resonance_half_in,
    // Drive outputs
    output logic [7:0] drive_level_out,
    output logic drive_brake_out,
    output logic drive_update_out,
    output logic loop_gain_reduce_out,
    output logic supply_correction_on_out,
    output logic commutation_out,
    // Timing outputs
    output logic adc_sample_out,
    output logic current_decay_out
);

    localparam drive_state_s RST_STATE = '{
        ctl2: `CTL2_RST, ctl3: `CTL3_RST, act2: `CTL2_RST, act3: `CTL3_RST, default: '0
    };
    localparam logic [15:0] WIN_LAST = 16'((32'h1 << DUTY_WIN_BITS) - 1);

    drive_state_s st_reg;
    drive_state_s st_next;

    input_source_e src;
    logic two_sided;
    logic closed_loop;
    logic [7:0] raw_level;
    logic [7:0] deviation;
    logic [7:0] gate_thr;
    logic [7:0] level;
    logic [7:0] drive_calc;
    logic brake_calc;
    logic [16:0] hc_full;
    logic [16:0] hc_scaled;
    logic pin_rise;
    logic commut_edge;
    logic half_evt;
    logic upd;
    logic [16:0] sample_len;
    logic [16:0] blank_len;
    logic [16:0] decay_len;
    logic sample_busy;
    logic sample_done;
    logic blank_done;
    logic decay_busy;

    // ----------------------------------------------------------------
    // Input selection and level mapping
    // ----------------------------------------------------------------
    assign src = (mode_in == `MODE_PIN_INPUT) ?
        (st_reg.ctl3[`CTL3_ANALOG_BIT] ? src_analog : src_pwm) : src_playback; // see R14

    always_comb begin
        unique case (src) // see R15
            src_pwm: raw_level = st_reg.duty;
            src_analog: raw_level = analog_level_in;
            src_playback: raw_level = st_reg.ctl3[`CTL3_SIGNEDNESS_BIT] ?
                real_time_playback_in : (real_time_playback_in ^ `LEVEL_MID); // see R12
            default: raw_level = `LEVEL_MID;
        endcase
    end

    assign two_sided = st_reg.ctl2[`CTL2_TWO_SIDED_BIT]; // see R01
    assign closed_loop = lra_select_in ? !st_reg.ctl3[`CTL3_FIXED_FREQ_BIT] // see R16
                                       : !st_reg.ctl3[`CTL3_ROT_LOOP_BIT]; // see R10

    always_comb begin
        if (!two_sided) begin
            deviation = raw_level;
        end else if (raw_level >= `LEVEL_MID) begin
            deviation = raw_level - `LEVEL_MID;
        end else begin
            deviation = `LEVEL_MID - raw_level;
        end
        unique case (st_reg.ctl3[`CTL3_GATE_HI:`CTL3_GATE_LO]) // see R09
            2'h0: gate_thr = 8'h00;
            2'h1: gate_thr = `GATE_THR_1;
            2'h2: gate_thr = `GATE_THR_2;
            2'h3: gate_thr = `GATE_THR_3;
        endcase
    end

    // Gate only the pin-driven sources
    assign level = (src != src_playback && deviation < gate_thr) ?
        (two_sided ? `LEVEL_MID : 8'h00) : raw_level; // see R09

    always_comb begin
        if (two_sided && !closed_loop) begin
            drive_calc = level ^ `LEVEL_MID; // see R03
            brake_calc = (level < `LEVEL_MID); // see R02
        end else if (two_sided) begin
            drive_calc = (level > `LEVEL_MID) ? (level - `LEVEL_MID) : 8'h00; // see R04
            brake_calc = feedback_brake_in;
        end else begin
            drive_calc = {1'b0, level[7:1]};
            brake_calc = closed_loop & feedback_brake_in;
        end
    end

    // ----------------------------------------------------------------
    // Duty measurement, commutation and update events
    // ----------------------------------------------------------------
    assign hc_full = st_reg.high_cnt + {16'h0000, trigger_input_pin_in};
    assign hc_scaled = 17'(hc_full << (16 - DUTY_WIN_BITS));
    assign pin_rise = trigger_input_pin_in & ~st_reg.pin_prev;
    assign commut_edge = pin_rise && (st_reg.edge_cnt == `COMMUT_EDGE_LAST); // see R17
    assign half_evt = (lra_select_in && st_reg.ctl3[`CTL3_FIXED_FREQ_BIT] && src == src_pwm) ?
        commut_edge : resonance_half_in;
    assign upd = lra_select_in ?
        (half_evt && (st_reg.ctl3[`CTL3_RATE_BIT] || !st_reg.phase)) : sample_done; // see R13

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    always_comb begin
        unique case (st_reg.act2[`CTL2_SAMPLE_HI:`CTL2_SAMPLE_LO]) // see R06
            2'h0: sample_len = SAMPLE_CYC0;
            2'h1: sample_len = SAMPLE_CYC1;
            2'h2: sample_len = SAMPLE_CYC2;
            2'h3: sample_len = SAMPLE_CYC3;
        endcase
    end

    assign blank_len = 17'(`BLANK_STEP_CYC) *
        ({15'h0000, st_reg.act2[`CTL2_BLANK_HI:`CTL2_BLANK_LO]} + 17'h00001); // see R07
    assign decay_len = 17'(`DECAY_STEP_CYC) *
        ({15'h0000, st_reg.act2[`CTL2_DECAY_HI:`CTL2_DECAY_LO]} + 17'h00001); // see R08

    interval_timer u_sample_timer (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .start_in(!sample_busy),
        .length_in(sample_len - 17'h00001), // Restart cycle is part of the interval
        .busy_out(sample_busy),
        .done_out(sample_done)
    );

    interval_timer u_blank_timer (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .start_in(sample_done),
        .length_in(blank_len),
        .busy_out(),
        .done_out(blank_done)
    );

    interval_timer u_decay_timer (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .start_in(upd),
        .length_in(decay_len),
        .busy_out(decay_busy),
        .done_out()
    );

    // ----------------------------------------------------------------
    // State update
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `CTL2_ADDR: st_next.rdata = st_reg.ctl2;
                `CTL3_ADDR: st_next.rdata = st_reg.ctl3;
                default: st_next.rdata = 8'h00;
            endcase
        end
        if (reg_wr_in) begin
            unique case (reg_addr_in) // see R18
                `CTL2_ADDR: st_next.ctl2 = reg_wdata_in;
                `CTL3_ADDR: st_next.ctl3 = reg_wdata_in;
                default: ;
            endcase
        end
        // Fixed power-of-two window keeps duty scaling a shift
        st_next.pin_prev = trigger_input_pin_in;
        if (st_reg.win_cnt == WIN_LAST) begin
            st_next.win_cnt = 16'h0000;
            st_next.high_cnt = 17'h00000;
            st_next.duty = hc_scaled[16] ? 8'hFF : hc_scaled[15:8]; // see R15
        end else begin
            st_next.win_cnt = st_reg.win_cnt + 16'h0001;
            st_next.high_cnt = hc_full;
        end
        if (pin_rise) begin
            st_next.edge_cnt = st_reg.edge_cnt + 6'h01;
        end
        if (commut_edge) begin
            st_next.commut = ~st_reg.commut; // see R17
        end
        if (half_evt) begin
            st_next.phase = ~st_reg.phase;
        end
        st_next.update = upd;
        if (upd) begin
            st_next.act2 = st_reg.ctl2; // see R18
            st_next.act3 = st_reg.ctl3;
            st_next.drive = drive_calc;
            st_next.brake = brake_calc;
        end
        st_next.gain_red = st_reg.act2[`CTL2_GAIN_REDUCE_BIT] & st_reg.brake
                           & brake_near_done_in; // see R05
        st_next.supply_on = !st_reg.act3[`CTL3_SUPPLY_OFF_BIT]; // see R11
        st_next.adc_sample = blank_done; // see R07
        st_next.decay = decay_busy; // see R08
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_reg <= RST_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out = st_reg.rdata;
    assign drive_level_out = st_reg.drive;
    assign drive_brake_out = st_reg.brake;
    assign drive_update_out = st_reg.update;
    assign loop_gain_reduce_out = st_reg.gain_red;
    assign supply_correction_on_out = st_reg.supply_on;
    assign commutation_out = st_reg.commut;
    assign adc_sample_out = st_reg.adc_sample;
    assign current_decay_out = st_reg.decay;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    property p_open_brake;
        upd && two_sided && !closed_loop |=> drive_brake_out == ($past(level) < `LEVEL_MID);
    endproperty
    a_open_brake: assert property (p_open_brake) else $error("open-loop brake wrong"); // see R02

    property p_open_map;
        upd && two_sided && !closed_loop |=> drive_level_out == ($past(level) ^ `LEVEL_MID);
    endproperty
    a_open_map: assert property (p_open_map) else $error("open-loop map wrong"); // see R03

    property p_closed_low;
        upd && two_sided && closed_loop && level <= `LEVEL_MID |=> drive_level_out == 8'h00;
    endproperty
    a_closed_low: assert property (p_closed_low) else $error("closed-loop low drive"); // see R04

    property p_gain_off;
        !st_reg.act2[`CTL2_GAIN_REDUCE_BIT] |=> !loop_gain_reduce_out;
    endproperty
    a_gain_off: assert property (p_gain_off) else $error("gain reduced while off"); // see R05

    property p_blank_sample;
        sample_done |-> ##[3:110] adc_sample_out;
    endproperty
    a_blank_sample: assert property (p_blank_sample) else $error("no converter sample"); // see R07

    property p_decay;
        upd |-> ##2 current_decay_out;
    endproperty
    a_decay: assert property (p_decay) else $error("no current decay"); // see R08

    property p_gate;
        upd && src != src_playback && two_sided && !closed_loop && deviation < gate_thr
        |=> drive_level_out == 8'h00;
    endproperty
    a_gate: assert property (p_gate) else $error("noise gate passed level"); // see R09

    property p_src;
        mode_in != `MODE_PIN_INPUT |-> src == src_playback;
    endproperty
    a_src: assert property (p_src) else $error("pin source outside mode"); // see R14

    property p_commut;
        $changed(commutation_out) |-> $past(commut_edge);
    endproperty
    a_commut: assert property (p_commut) else $error("commutation without edge"); // see R17

    property p_unmapped;
        reg_wr_in && reg_addr_in != `CTL2_ADDR && reg_addr_in != `CTL3_ADDR
        |=> $stable(st_reg.ctl2) && $stable(st_reg.ctl3);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write changed state"); // see R18

    c_pwm_update: cover property (upd && src == src_pwm);
    c_commut: cover property (commut_edge);
    c_brake: cover property (drive_brake_out && loop_gain_reduce_out);

endmodule

`default_nettype wire

// ### sim/haptic_source_model.sv
// Host-side PWM source that drives the trigger input pin
`timescale 1ns/1ns
`default_nettype none

module haptic_source_model (
    // Clock
    input wire logic clk_sys_in,
    // Control
    input wire logic pwm_enable_in,
    input wire logic [7:0] period_in,
    input wire logic [7:0] high_in,
    // Pin
    output logic trigger_input_pin_out
);
    logic [7:0] phase_reg;

    initial begin
        phase_reg = 8'h00;
        trigger_input_pin_out = 1'b0;
    end

    // ----
    // Square wave, held low while disabled
    // ----
    always @(negedge clk_sys_in) begin
        if (!pwm_enable_in) begin
            phase_reg <= 8'h00;
            trigger_input_pin_out <= 1'b0;
        end else begin
            phase_reg <= (phase_reg + 8'h01 >= period_in) ? 8'h00 : phase_reg + 8'h01;
            trigger_input_pin_out <= (phase_reg < high_in);
        end
    end
endmodule

`default_nettype wire

// ### sim/haptic_drive_config_regs_test.sv
// Self-checking bench for the drive configuration registers
`timescale 1ns/1ns
`default_nettype none
`include "haptic_drive_map.svh"

module haptic_drive_config_regs_test;
    localparam logic [16:0] SAMP [4] = '{17'h000C8, 17'h000F0, 17'h00118, 17'h00140};
    // mode, control two, control three, input value, drive, feedback, brake
    localparam logic [55:0] MAP [23] = '{
        56'h00_DA_28_00_80_00_01, 56'h00_9A_28_40_C0_00_01, 56'h00_DA_28_80_00_00_00,
        56'h00_DA_28_C0_40_00_00, 56'h00_DA_28_FF_7F_00_00, 56'h00_DA_38_FF_7F_00_00,
        56'h00_DA_20_00_00_00_00, 56'h00_DA_20_FF_FF_00_01, 56'h00_DA_08_40_00_01_01,
        56'h00_DA_08_C0_40_00_00, 56'h00_DA_08_FF_7F_01_01, 56'h00_5A_08_FF_7F_01_01,
        56'h00_5A_28_80_40_01_00, 56'h03_DA_22_84_04_00_00, 56'h03_DA_62_84_00_00_00,
        56'h03_DA_62_85_05_00_00, 56'h03_DA_A2_89_00_00_00, 56'h03_DA_A2_8A_0A_00_00,
        56'h03_DA_E2_93_00_00_00, 56'h03_DA_E2_94_14_00_00, 56'h03_DA_E2_6C_EC_00_01,
        56'h03_DA_20_C0_40_00_00, 56'h05_DA_2A_C0_40_00_00};

    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [2:0] mode_in = 3'h0;
    logic lra_select_in = 1'b0;
    logic [7:0] real_time_playback_in = 8'h00;
    logic [7:0] analog_level_in = 8'h00;
    logic trigger_input_pin_in;
    logic feedback_brake_in = 1'b0;
    logic brake_near_done_in = 1'b1;
    logic resonance_half_in = 1'b0;
    logic [7:0] drive_level_out;
    logic drive_brake_out, drive_update_out, loop_gain_reduce_out;
    logic supply_correction_on_out, commutation_out, adc_sample_out, current_decay_out;
    logic pwm_en = 1'b0;
    logic [55:0] e;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int gap, hi, n_adc, at_adc, n;

    haptic_drive_config_regs #(
        .SAMPLE_CYC0(SAMP[0]), .SAMPLE_CYC1(SAMP[1]), .SAMPLE_CYC2(SAMP[2]),
        .SAMPLE_CYC3(SAMP[3]), .DUTY_WIN_BITS(8)
    ) i_haptic_drive_config_regs (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .mode_in(mode_in), .lra_select_in(lra_select_in),
        .real_time_playback_in(real_time_playback_in), .analog_level_in(analog_level_in),
        .trigger_input_pin_in(trigger_input_pin_in), .feedback_brake_in(feedback_brake_in),
        .brake_near_done_in(brake_near_done_in), .resonance_half_in(resonance_half_in),
        .drive_level_out(drive_level_out), .drive_brake_out(drive_brake_out),
        .drive_update_out(drive_update_out), .loop_gain_reduce_out(loop_gain_reduce_out),
        .supply_correction_on_out(supply_correction_on_out),
        .commutation_out(commutation_out), .adc_sample_out(adc_sample_out),
        .current_decay_out(current_decay_out)
    );

    // Period 4 with 3 high: duty 75 percent
    haptic_source_model i_haptic_source_model (
        .clk_sys_in(clk_sys_in), .pwm_enable_in(pwm_en), .period_in(8'h04),
        .high_in(8'h03), .trigger_input_pin_out(trigger_input_pin_in)
    );

    initial begin
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    // ----
    // Checks and register access
    // ----
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            n_fail++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(negedge clk_sys_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clk_sys_in);
        reg_rd_in = 1'b0;
        chk8(reg_rdata_out, x);
    endtask

    task automatic wait_upd();
        int k = 0;
        do begin
            @(negedge clk_sys_in);
            k++;
        end while (drive_update_out !== 1'b1 && k < 2000);
        chk_n(int'(k < 2000), 1);
    endtask

    task automatic measure();
        gap = 0;
        hi = 0;
        n_adc = 0;
        at_adc = 0;
        do begin
            @(negedge clk_sys_in);
            gap++;
            hi += int'(current_decay_out === 1'b1);
            if (adc_sample_out === 1'b1) begin
                n_adc++;
                at_adc = gap;
            end
        end while (drive_update_out !== 1'b1 && gap < 1000);
    endtask

    task automatic half();
        @(negedge clk_sys_in);
        resonance_half_in = 1'b1;
        for (int t = 0; t < 10; t++) begin
            @(negedge clk_sys_in);
            resonance_half_in = 1'b0;
            n += int'(drive_update_out === 1'b1);
        end
    endtask

    task automatic tog();
        logic was;
        was = commutation_out;
        gap = 0;
        do begin
            @(negedge clk_sys_in);
            gap++;
        end while (commutation_out === was && gap < 2000);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    // ----
    // Test sequence
    // ----
    initial begin
        repeat (20) @(negedge clk_sys_in);
        srst_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk8({7'h00, supply_correction_on_out}, 8'h01);
        rd(`CTL2_ADDR, `CTL2_RST);
        rd(`CTL3_ADDR, `CTL3_RST);
        wr(8'h1E, 8'hFF);
        rd(8'h1E, 8'h00);
        rd(`CTL2_ADDR, `CTL2_RST);
        wr(`CTL3_ADDR, 8'h5A);
        rd(`CTL3_ADDR, 8'h5A);
        for (int i = 0; i < 23; i++) begin
            e = MAP[i];
            @(negedge clk_sys_in);
            mode_in = e[50:48];
            real_time_playback_in = (e[55:48] == 8'h03) ? ~e[31:24] : e[31:24];
            analog_level_in = (e[55:48] == 8'h03) ? e[31:24] : ~e[31:24];
            feedback_brake_in = e[8];
            brake_near_done_in = (i != 0);
            pwm_en = (e[55:48] == 8'h03) && !e[33];
            wr(`CTL2_ADDR, e[47:40]);
            wr(`CTL3_ADDR, e[39:32]);
            repeat (4) wait_upd(); // Duty needs one full window after enable
            chk8(drive_level_out, e[23:16]);
            chk8({7'h00, drive_brake_out}, e[7:0]);
            chk8({7'h00, supply_correction_on_out}, {7'h00, !e[36]});
            @(negedge clk_sys_in);
            chk8({7'h00, loop_gain_reduce_out}, {7'h00, e[46] & e[0] & (i != 0)});
        end
        mode_in = 3'h0;
        pwm_en = 1'b0;
        wr(`CTL3_ADDR, 8'h28);
        for (int c = 0; c < 4; c++) begin
            wr(`CTL2_ADDR, {2'b11, c[1:0], c[1:0], c[1:0]});
            repeat (2) wait_upd();
            measure();
            chk_n(gap, int'(SAMP[c]));
            chk_n(hi, (c + 1) * 25);
            chk_n(n_adc, 1);
            chk_n(int'(at_adc > c * 25 + 20 && at_adc < c * 25 + 36), 1);
        end
        lra_select_in = 1'b1;
        for (int r = 0; r < 2; r++) begin
            wr(`CTL3_ADDR, r ? 8'h24 : 8'h20);
            repeat (4) half();
            n = 0;
            repeat (8) half();
            chk_n(n, r ? 8 : 4);
        end
        mode_in = 3'h3;
        pwm_en = 1'b1;
        wr(`CTL3_ADDR, 8'h21);
        repeat (2) half();
        tog();
        tog();
        chk_n(gap, 64 * 4);
        stop_test();
    end
endmodule

`default_nettype wire
